/* File: dv/d2d_slice_control_handshake_tb.sv */
// Self-checking bench for the slice control block
`timescale 1ns/1ps
`default_nettype none
module d2d_slice_control_handshake_tb import dsc_pkg::*;;
  localparam int WW = PD_W + 2 * SIDE_W; // Word plus side wires
  logic clk_sys = 1'b0;
  logic resetn, clk_en, slice_reset_n, cfg_is_tx, cfg_align_by_timer;
  logic rx_dll_locked, tx_clock_gate_request, pclk_out, rx_word_valid;
  logic slice_ready, fwd_clock_enable, tx_clock_gated, speed_grade_error;
  logic [2:0] cfg_speed_grade;
  logic [1:0] cfg_div_log2;
  logic [15:0] tx_serial_clock_mhz;
  logic [PD_W-1:0] tx_parallel_data, rx_wire_data;
  logic [PD_W-1:0] tx_wire_data, rx_parallel_data;
  logic [SIDE_W-1:0] tx_error_correction_wire, tx_aux_wire, rx_wire_fec;
  logic [SIDE_W-1:0] rx_wire_aux, tx_wire_fec, tx_wire_aux;
  logic [SIDE_W-1:0] rx_error_correction_wire, rx_aux_wire;
  logic [WW-1:0] tx_prev, tx_last, tx_now, rx_seen; // Model state
  int mismatches = 0, checks = 0, seed = 71558;
  int gap, n, tmp, rx_n, d, g, gap_ok;
  int hi; // Cycles with the parallel clock seen high
  int rate[6] = '{2, 4, 8, 16, 24, 32}; // Gbps per wire of each grade
  dsc_slice_ctrl dsc_slice_ctrl_i (.clk_sys, .resetn, .clk_en,
    .slice_reset_n, .cfg_is_tx, .cfg_speed_grade, .cfg_div_log2,
    .cfg_align_by_timer, .rx_dll_locked, .tx_clock_gate_request,
    .tx_parallel_data, .tx_error_correction_wire, .tx_aux_wire,
    .rx_wire_data, .rx_wire_fec, .rx_wire_aux, .slice_ready, .pclk_out,
    .fwd_clock_enable, .tx_clock_gated, .speed_grade_error,
    .tx_serial_clock_mhz, .tx_wire_data, .tx_wire_fec, .tx_wire_aux,
    .rx_parallel_data, .rx_error_correction_wire, .rx_aux_wire,
    .rx_word_valid);
  dsc_far_end dsc_far_end_i (.clk_sys, .rx_wire_data, .rx_wire_fec,
    .rx_wire_aux);
  always #4 clk_sys = ~clk_sys;
  // Word the design sees at each edge
  always @(posedge clk_sys) begin
    rx_seen <= {rx_wire_data, rx_wire_fec, rx_wire_aux};
  end
  task automatic chk_word(string nm, logic [WW-1:0] e, logic [WW-1:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word
  task automatic chk_flag(string nm, logic e, logic s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_flag
  task test_done;
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // One cycle: compare a changed transmit word and any receive word, then drive random words while ready, else zeros
  task step;
    @(posedge clk_sys);
    #1;
    gap++;
    hi += (pclk_out === 1'b1);
    // Word the link layer presented at the edge just passed
    tx_prev = {tx_parallel_data, tx_error_correction_wire, tx_aux_wire};
    tx_now = {tx_wire_data, tx_wire_fec, tx_wire_aux};
    if (slice_ready !== 1'b1) gap_ok = 0;
    if (slice_ready === 1'b1 && cfg_is_tx === 1'b1 &&
        tx_now !== tx_last) begin
      chk_word("tx_wire", tx_prev, tx_now);
      if (gap_ok != 0) chk_word("word_gap", WW'(1 << d), WW'(gap));
      gap_ok = 1;
      gap = 0;
    end
    tx_last = tx_now;
    if (rx_word_valid === 1'b1) begin
      chk_word("rx_word", rx_seen, {rx_parallel_data,
        rx_error_correction_wire, rx_aux_wire});
      rx_n++;
    end
    tmp = $random(seed);
    // Link layer offers mission words only while the slice is ready
    if (slice_ready === 1'b1) begin
      tx_parallel_data = {$random(seed), $random(seed), $random(seed), tmp};
      tx_error_correction_wire = tmp[15:8];
      tx_aux_wire = tmp[23:16];
    end else begin
      tx_parallel_data = '0;
      tx_error_correction_wire = '0;
      tx_aux_wire = '0;
    end
  endtask : step
  // Bounded wait; running out ends the run as a failure
  task wait_ready(input int lim);
    n = 0;
    while (slice_ready !== 1'b1) begin
      if (n >= lim) begin
        mismatches++;
        test_done;
      end
      step;
      n++;
    end
  endtask : wait_ready
  // Supervisor initializes the slice with a fresh role; the role only
  // changes once reset is taken, so a stale ready never meets it
  task start_slice(input logic tx, input logic tmr);
    step;
    slice_reset_n = 1'b0;
    step;
    cfg_is_tx = tx;
    cfg_align_by_timer = tmr;
    repeat (2) step;
    chk_flag("ready_in_reset", 1'b0, slice_ready);
    slice_reset_n = 1'b1;
  endtask : start_slice
  initial begin
    resetn = 1'b0;
    slice_reset_n = 1'b0;
    clk_en = 1'b1;
    cfg_is_tx = 1'b1;
    cfg_align_by_timer = 1'b0;
    rx_dll_locked = 1'b0;
    tx_clock_gate_request = 1'b0;
    tx_parallel_data = '0;
    tx_error_correction_wire = '0;
    tx_aux_wire = '0;
    tx_last = '0;
    gap = 0;
    gap_ok = 0;
    g = {$random(seed)} % 6;
    d = 1 + {$random(seed)} % 3;
    cfg_speed_grade = 3'(g);
    cfg_div_log2 = 2'(d);
    repeat (3) step;
    resetn = 1'b1;
    // Transmit slice: clocks, ready, then back-to-back words
    start_slice(1'b1, 1'b0);
    wait_ready(100);
    chk_flag("fwd_clock", 1'b1, fwd_clock_enable);
    chk_word("serial_mhz", WW'(rate[g]*500), WW'(tx_serial_clock_mhz));
    // Parallel clock runs free, high for half of every word
    hi = 0;
    repeat (40) step;
    chk_word("pclk_duty", WW'(20), WW'(hi));
    // Gate request honoured by the next word edge
    tx_clock_gate_request = 1'b1;
    n = 0;
    while (tx_clock_gated !== 1'b1 && n <= 8) begin
      step;
      n++;
    end
    chk_flag("gate_in_word", 1'b1, n <= (1 << d));
    // A gate that never came has been counted; stop here
    if (n > 8) test_done;
    chk_flag("ready_gated", 1'b0, slice_ready);
    repeat (5) step;
    tx_clock_gate_request = 1'b0;
    step;
    chk_flag("ready_ungated", 1'b1, slice_ready);
    repeat (30) step;
    // Receive slice on the alignment timer
    start_slice(1'b0, 1'b1);
    // Clock enable low freezes the slice, so the timer starts late
    clk_en = 1'b0;
    repeat (10) step;
    clk_en = 1'b1;
    wait_ready(200);
    chk_flag("rx_timer", 1'b1, n >= RX_ALIGN_CYCLES &&
      n <= RX_ALIGN_CYCLES + 6);
    rx_n = 0;
    repeat (32) step;
    chk_flag("rx_rate", 1'b1, rx_n >= (32 >> d) - 1 &&
      rx_n <= (32 >> d) + 1);
    // Receive slice waiting on lock
    start_slice(1'b0, 1'b0);
    repeat (20) step;
    chk_flag("lock_wait", 1'b0, slice_ready);
    rx_dll_locked = 1'b1;
    wait_ready(4);
    // Unsupported grade never reaches ready
    cfg_speed_grade = 3'(6 + {$random(seed)} % 2);
    start_slice(1'b1, 1'b0);
    repeat (40) step;
    chk_flag("grade_err", 1'b1, speed_grade_error);
    chk_flag("grade_ready", 1'b0, slice_ready);
    chk_word("bad_mhz", '0, WW'(tx_serial_clock_mhz));
    test_done;
  end
endmodule : d2d_slice_control_handshake_tb
bind dsc_slice_ctrl dsc_slice_checker dsc_slice_checker_i (.clk_sys,
  .resetn, .slice_reset_n, .cfg_is_tx, .cfg_speed_grade, .rx_wire_data,
  .slice_ready, .fwd_clock_enable, .tx_clock_gated, .speed_grade_error,
  .rx_parallel_data, .rx_word_valid);
`default_nettype wire

/* File: dv/dsc_far_end.sv */
// Far transmitter model: receive words that change every cycle
`timescale 1ns/1ps
`default_nettype none
module dsc_far_end
  import dsc_pkg::*;
(
  output logic [PD_W-1:0] rx_wire_data,
  output logic [SIDE_W-1:0] rx_wire_fec,
  output logic [SIDE_W-1:0] rx_wire_aux,
  input wire logic clk_sys
);
  int sq; // Pattern step; a stale word can then never match
  // Training data flows from time zero, before release
  initial begin
    sq = 0;
    forever begin
      #1;
      sq = sq + 1;
      // Only training words here; supervisor traffic uses other paths
      rx_wire_data = {4{sq * 32'h9E3779B1}};
      rx_wire_fec = sq[7:0];
      rx_wire_aux = sq[15:8];
      @(posedge clk_sys);
    end
  end
endmodule : dsc_far_end
`default_nettype wire

/* File: dv/dsc_slice_checker.sv */
// Port assertions for the slice control block
`timescale 1ns/1ps
`default_nettype none
module dsc_slice_checker
  import dsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slice_reset_n,
  input wire logic cfg_is_tx,
  input wire logic [2:0] cfg_speed_grade,
  input wire logic [PD_W-1:0] rx_wire_data,
  input wire logic slice_ready,
  input wire logic fwd_clock_enable,
  input wire logic tx_clock_gated,
  input wire logic speed_grade_error,
  input wire logic [PD_W-1:0] rx_parallel_data,
  input wire logic rx_word_valid
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ready_in_reset: assert property (!slice_reset_n |=> !slice_ready)
    else $error("ready high in slice reset");
  a_align_first: assert property ($rose(slice_reset_n) |->
    !slice_ready[*2]) else $error("ready without alignment");
  a_rx_valid_pulse: assert property (rx_word_valid |=> !rx_word_valid)
    else $error("receive valid longer than a cycle");
  a_rx_valid_cause: assert property (rx_word_valid |-> !cfg_is_tx
    && $past(slice_ready)) else $error("receive word while not ready");
  a_rx_word_copy: assert property (rx_word_valid |->
    rx_parallel_data == $past(rx_wire_data))
    else $error("receive word altered");
  a_gated_quiet: assert property (tx_clock_gated |->
    !slice_ready && !fwd_clock_enable) else $error("gated but ready");
  a_tx_clock_on: assert property (slice_ready && cfg_is_tx |->
    fwd_clock_enable) else $error("ready without forwarded clock");
  a_bad_grade: assert property ($past(resetn) &&
    $past(cfg_speed_grade) > 3'h5 |-> speed_grade_error)
    else $error("bad grade not flagged");
endmodule : dsc_slice_checker
`default_nettype wire

/* File: src/dsc_clk_div.sv */
// Power-of-two divider that derives the parallel clock and word edges
`timescale 1ns/1ps
`default_nettype none

module dsc_clk_div
  import dsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  dsc_clk_if.div cif
);

  logic [DIV_CNT_W-1:0] count_reg; // Position inside the parallel word
  logic [1:0] ratio_log2; // Exponent, never below the minimum
  logic [DIV_CNT_W-1:0] div_max; // Last count of a word

  // Exponent zero would give no clock edge, so clamp it
  always_comb begin
    ratio_log2 = (cif.div_log2 < DIV_LOG2_MIN) ? DIV_LOG2_MIN : cif.div_log2;
    div_max = DIV_CNT_W'((4'h1 << ratio_log2) - 4'h1);
  end

  // Word counter; held at zero while stopped so restart is aligned
  always_ff @(posedge clk_sys) begin
    if (!resetn || !cif.run) begin
      count_reg <= '0;
    end else if (clk_en) begin
      count_reg <= (count_reg == div_max) ? '0 : count_reg + 3'h1;
    end
  end

  // Word edge on the last count; clock high for the first half
  assign cif.word_edge = cif.run && clk_en && (count_reg == div_max);
  assign cif.pclk_level = cif.run && (count_reg <= (div_max >> 1));

endmodule : dsc_clk_div

`default_nettype wire

/* File: src/dsc_clk_if.sv */
// Bundle between the slice control and its parallel clock divider
`timescale 1ns/1ps
`default_nettype none

interface dsc_clk_if;
  logic run; // Divider runs while high
  logic [1:0] div_log2; // Power-of-two exponent of the divide
  logic word_edge; // One-cycle pulse on each parallel word boundary
  logic pclk_level; // Level of the derived parallel clock

  modport ctrl (output run, output div_log2, input word_edge,
    input pclk_level);
  modport div (input run, input div_log2, output word_edge,
    output pclk_level);
endinterface : dsc_clk_if

`default_nettype wire

/* File: src/dsc_pkg.sv */
// Shared constants and types for the die-to-die slice control block
package dsc_pkg;

  // Serialization ratio N between the wire rate and the parallel rate
  localparam int SER_RATIO = 8;
  // Parallel data width is sixteen data wires times N
  localparam int PD_W = 16 * SER_RATIO;
  // Width of each optional side wire (error correction, auxiliary)
  localparam int SIDE_W = SER_RATIO;

  // Clock period of clk_sys in picoseconds (125 MHz)
  localparam int CLK_PERIOD_PS = 8000;
  // Receive alignment timer length in nanoseconds (least time)
  localparam int RX_ALIGN_TIME_NS = 1000;
  // Same time in clk_sys cycles, rounded up
  localparam int RX_ALIGN_CYCLES =
    (RX_ALIGN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Width of the alignment timer
  localparam int ALIGN_CNT_W = 8;
  localparam logic [ALIGN_CNT_W-1:0] ALIGN_DONE_COUNT =
    ALIGN_CNT_W'(RX_ALIGN_CYCLES);
  // Word edges a transmit slice counts in alignment before the next word edge makes it ready
  localparam logic [ALIGN_CNT_W-1:0] TX_ALIGN_WORDS = 8'h04;

  // Divider counter width and the smallest power-of-two exponent
  localparam int DIV_CNT_W = 3;
  localparam logic [1:0] DIV_LOG2_MIN = 2'h1;

  // Speed grade codes, one per defined grade
  localparam logic [2:0] GRADE_2G = 3'h0;
  localparam logic [2:0] GRADE_4G = 3'h1;
  localparam logic [2:0] GRADE_8G = 3'h2;
  localparam logic [2:0] GRADE_16G = 3'h3;
  localparam logic [2:0] GRADE_24G = 3'h4;
  localparam logic [2:0] GRADE_32G = 3'h5;
  // Grades this slice supports, one bit per grade code
  localparam logic [5:0] GRADES_SUPPORTED = 6'h3F;

  // Serial clock in MHz is half the wire rate of the grade
  function automatic logic [15:0] dsc_grade_mhz(input logic [2:0] grade);
    logic [15:0] mhz;
    mhz = 16'h0000;
    case (grade)
      GRADE_2G: mhz = 16'h03E8;
      GRADE_4G: mhz = 16'h07D0;
      GRADE_8G: mhz = 16'h0FA0;
      GRADE_16G: mhz = 16'h1F40;
      GRADE_24G: mhz = 16'h2EE0;
      GRADE_32G: mhz = 16'h3E80;
      default: mhz = 16'h0000;
    endcase
    return mhz;
  endfunction : dsc_grade_mhz

  // Slice control states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_ALIGN = 2'b01,
    ST_READY = 2'b10,
    ST_GATED = 2'b11
  } dsc_state_t;

endpackage : dsc_pkg

/* File: src/dsc_slice_ctrl.sv */
// Control, readiness and data handoff of one die-to-die slice
//
// Overview of operation
// R1 - Slice reset input low resets the slice
// R2 - Slice stays in reset state while asserted
// R3 - Self-align after reset release before ready
// R4 - Supervisor asserts reset to initialize the slice
// R5 - Transmit ready only with clocks driven
// R6 - Ready is active high, one means ready
// R7 - Far transmitter sends clock and training on release
// R8 - Receive ready after alignment, timer or lock
// R9 - Receive data delivered while ready is correct
// R10 - Clock-gate request gates at next word edge
// R11 - Programming port controls and reports status
// R12 - Supervisor outside the slice manages initialization
// R13 - Supervisor messages never use the data wires
// R14 - Support wire rate grades two to 32
// R15 - Parallel side single data rate, 16N wide
// R16 - Parallel clock is serial clock over 2^n
// R17 - Side wires passed through like data bits
// R18 - Ready low in reset and until aligned
// R19 - Link layer waits for ready before data
`timescale 1ns/1ps
`default_nettype none

module dsc_slice_ctrl
  import dsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Link supervisor controls
  input wire logic slice_reset_n,
  input wire logic cfg_is_tx,
  input wire logic [2:0] cfg_speed_grade,
  input wire logic [1:0] cfg_div_log2,
  input wire logic cfg_align_by_timer,
  input wire logic rx_dll_locked,
  input wire logic tx_clock_gate_request,
  // Link layer transmit word
  input wire logic [PD_W-1:0] tx_parallel_data,
  input wire logic [SIDE_W-1:0] tx_error_correction_wire,
  input wire logic [SIDE_W-1:0] tx_aux_wire,
  // Deserializer receive word
  input wire logic [PD_W-1:0] rx_wire_data,
  input wire logic [SIDE_W-1:0] rx_wire_fec,
  input wire logic [SIDE_W-1:0] rx_wire_aux,
  // Status toward link layer and supervisor
  output logic slice_ready,
  output logic pclk_out,
  output logic fwd_clock_enable,
  output logic tx_clock_gated,
  output logic speed_grade_error,
  output logic [15:0] tx_serial_clock_mhz,
  // Serializer transmit word
  output logic [PD_W-1:0] tx_wire_data,
  output logic [SIDE_W-1:0] tx_wire_fec,
  output logic [SIDE_W-1:0] tx_wire_aux,
  // Link layer receive word
  output logic [PD_W-1:0] rx_parallel_data,
  output logic [SIDE_W-1:0] rx_error_correction_wire,
  output logic [SIDE_W-1:0] rx_aux_wire,
  output logic rx_word_valid
);

  dsc_state_t state_reg; // Slice control state
  dsc_state_t state_next; // Next state
  logic [ALIGN_CNT_W-1:0] align_cnt_reg; // Alignment timer or word count
  logic align_done; // Alignment finished this cycle
  logic grade_ok; // Selected grade is supported
  logic in_reset; // Either reset is active
  logic slice_ready_reg; // Ready flag
  logic pclk_reg; // Registered parallel clock
  logic fwd_en_reg; // Forwarded clock enable
  logic gated_reg; // Transmit clock gated
  logic grade_err_reg; // Unsupported grade
  logic [15:0] mhz_reg; // Serial clock rate in MHz
  logic [PD_W-1:0] txd_reg; // Transmit data word
  logic [SIDE_W-1:0] txf_reg; // Transmit error correction bits
  logic [SIDE_W-1:0] txa_reg; // Transmit auxiliary bits
  logic [PD_W-1:0] rxd_reg; // Receive data word
  logic [SIDE_W-1:0] rxf_reg; // Receive error correction bits
  logic [SIDE_W-1:0] rxa_reg; // Receive auxiliary bits
  logic rx_valid_reg; // Receive word strobe

  dsc_clk_if cif (); // Bundle to the divider

  // Parallel clock divider; word edges pace every parallel transfer
  dsc_clk_div u_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .cif(cif)
  );

  // Either the system reset or the slice reset holds all but the grade status, which only the system reset clears
  assign in_reset = !resetn || !slice_reset_n; // R1

  // A grade outside the supported set blocks readiness
  assign grade_ok = (cfg_speed_grade <= GRADE_32G) &&
    GRADES_SUPPORTED[cfg_speed_grade]; // R14

  // The divider runs out of reset on a transmit slice so that the
  // forwarded and parallel clocks are valid before ready; a receive
  // slice runs it too, since its parallel clock is derived the same way
  assign cif.run = !in_reset && grade_ok && (state_reg != ST_GATED);
  assign cif.div_log2 = cfg_div_log2; // R16

  // Transmit alignment counts word edges of a running clock; receive
  // alignment uses either the timer or the delay-line lock input
  always_comb begin
    if (cfg_is_tx) begin
      align_done = cif.word_edge && (align_cnt_reg >= TX_ALIGN_WORDS); // R5
    end else if (cfg_align_by_timer) begin
      align_done = (align_cnt_reg >= ALIGN_DONE_COUNT); // R8
    end else begin
      align_done = rx_dll_locked; // R8
    end
  end

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        // Leaving reset always passes through alignment
        state_next = ST_ALIGN; // R3
      end
      ST_ALIGN: begin
        // Hold here until aligned and the grade is legal
        if (align_done && grade_ok) begin
          state_next = ST_READY; // R3
        end
      end
      ST_READY: begin
        // Gate only on a word boundary, so no partial word goes out
        if (!grade_ok) begin
          state_next = ST_ALIGN;
        end else if (cfg_is_tx && tx_clock_gate_request &&
            cif.word_edge) begin
          state_next = ST_GATED; // R10
        end
      end
      ST_GATED: begin
        // The divider is stopped here, so resume straight away and
        // let the restarted divider realign the first word
        if (!tx_clock_gate_request || !cfg_is_tx) begin
          state_next = ST_READY;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // State register; any reset forces the reset state
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      state_reg <= ST_RESET; // R2
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Alignment counter; counts cycles for the receive timer and
  // word edges on a transmit slice, saturating at its top
  always_ff @(posedge clk_sys) begin
    if (in_reset || state_reg != ST_ALIGN) begin
      align_cnt_reg <= '0;
    end else if (clk_en && align_cnt_reg != {ALIGN_CNT_W{1'b1}}) begin
      if (!cfg_is_tx || cif.word_edge) begin
        align_cnt_reg <= align_cnt_reg + 8'h01;
      end
    end
  end

  // Ready flag follows the next state so it rises with READY entry
  // and is low in reset, alignment and while gated
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      slice_ready_reg <= 1'b0; // R18
    end else if (clk_en) begin
      slice_ready_reg <= (state_next == ST_READY); // R6
    end
  end

  // Clock outputs; the forwarded clock runs whenever the divider runs
  // on a transmit slice, and stops in the gated state
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      pclk_reg <= 1'b0;
      fwd_en_reg <= 1'b0;
      gated_reg <= 1'b0;
    end else if (clk_en) begin
      pclk_reg <= cif.pclk_level; // R16
      fwd_en_reg <= cfg_is_tx && (state_next != ST_GATED) && grade_ok; // R5
      gated_reg <= (state_next == ST_GATED); // R10
    end
  end

  // Grade status; the rate report lets the supervisor confirm the
  // programmed grade, which stands in for a register readback
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      grade_err_reg <= 1'b0;
      mhz_reg <= 16'h0000;
    end else if (clk_en) begin
      grade_err_reg <= !grade_ok; // R11
      mhz_reg <= dsc_grade_mhz(cfg_speed_grade); // R14
    end
  end

  // Transmit word capture; the link layer is expected to hold its
  // data until ready, so non-ready words are sent as zero
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      txd_reg <= '0;
      txf_reg <= '0;
      txa_reg <= '0;
    end else if (clk_en && cif.word_edge) begin
      if (cfg_is_tx && state_reg == ST_READY) begin
        txd_reg <= tx_parallel_data; // R15
        txf_reg <= tx_error_correction_wire; // R17
        txa_reg <= tx_aux_wire; // R17
      end else begin
        txd_reg <= '0; // R19
        txf_reg <= '0;
        txa_reg <= '0;
      end
    end
  end

  // Receive word delivery; one strobe per parallel word, only while
  // ready, so no word captured before alignment reaches the link layer
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      rxd_reg <= '0;
      rxf_reg <= '0;
      rxa_reg <= '0;
      rx_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rx_valid_reg <= 1'b0;
      if (!cfg_is_tx && cif.word_edge && state_reg == ST_READY) begin
        rxd_reg <= rx_wire_data; // R9
        rxf_reg <= rx_wire_fec; // R17
        rxa_reg <= rx_wire_aux; // R17
        rx_valid_reg <= 1'b1; // R9
      end
    end
  end

  // Outputs come straight from flip-flops
  assign slice_ready = slice_ready_reg;
  assign pclk_out = pclk_reg;
  assign fwd_clock_enable = fwd_en_reg;
  assign tx_clock_gated = gated_reg;
  assign speed_grade_error = grade_err_reg;
  assign tx_serial_clock_mhz = mhz_reg;
  assign tx_wire_data = txd_reg;
  assign tx_wire_fec = txf_reg;
  assign tx_wire_aux = txa_reg;
  assign rx_parallel_data = rxd_reg;
  assign rx_error_correction_wire = rxf_reg;
  assign rx_aux_wire = rxa_reg;
  assign rx_word_valid = rx_valid_reg;

endmodule : dsc_slice_ctrl

`default_nettype wire
